// ===== rtl/chg_pkg.sv
// Constants and types shared by the charger control register bank.
package chg_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] CHG_CONFIG_ADDR = 8'h01;
  localparam logic [7:0] CHG_FLOAT_ADDR = 8'h02;
  localparam logic [7:0] CHG_ID_ADDR = 8'h03;
  localparam logic [7:0] CHG_ID_ALIAS_ADDR = 8'h3b;
  localparam logic [7:0] CHG_CURRENT_ADDR = 8'h04;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CHG_CONFIG_RESET = 8'h30;
  localparam logic [7:0] CHG_FLOAT_RESET = 8'h0a;
  localparam logic [7:0] CHG_CURRENT_RESET = 8'h89;
  localparam logic [7:0] CHG_UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CHG_INCAP_LSB = 6;
  localparam int CHG_WEAK_LSB = 4;
  localparam int CHG_CUTOFF_BIT = 3;
  localparam int CHG_DISABLE_BIT = 2;
  localparam int CHG_HIZ_BIT = 1;
  localparam int CHG_BOOST_BIT = 0;
  localparam int CHG_FLOAT_LSB = 2;
  localparam int CHG_OTG_POL_BIT = 1;
  localparam int CHG_OTG_EN_BIT = 0;
  localparam int CHG_SUPPLIER_LSB = 5;
  localparam int CHG_VARIANT_LSB = 3;
  localparam int CHG_REVISION_LSB = 0;
  localparam int CHG_PARAM_RESET_BIT = 7;
  localparam int CHG_MAXCUR_LSB = 4;
  localparam int CHG_RESERVED_BIT = 3;
  localparam int CHG_CUTCUR_LSB = 0;

  // ----------------------------------------------------------------
  // Bus constants
  // ----------------------------------------------------------------
  localparam logic [6:0] CHG_SLAVE_ADDR = 7'h6b;
  // Arbitrary neutral identity values.
  localparam logic [2:0] CHG_SUPPLIER_CODE = 3'h2;
  localparam logic [1:0] CHG_VARIANT_CODE = 2'h0;
  localparam logic [2:0] CHG_REVISION_CODE = 3'h0;
  localparam logic [3:0] CHG_BYTE_BITS = 4'h8;

  typedef enum logic [3:0] {
    CHG_IDLE,
    CHG_DEV_ADDR,
    CHG_DEV_ACK,
    CHG_REG_ADDR,
    CHG_REG_ACK,
    CHG_WR_DATA,
    CHG_WR_ACK,
    CHG_RD_DATA,
    CHG_RD_ACK
  } chg_bus_state_t;

endpackage : chg_pkg

// ===== rtl/chg_line_if.sv
// Filtered two-wire bus levels passed from the pin filter to the register bank.
`timescale 1ns/1ps
`default_nettype none
interface chg_line_if;
  logic [1:0] level;

  modport filt (
    output level
  );
  modport core (
    input level
  );
endinterface : chg_line_if
`default_nettype wire

// ===== rtl/chg_pin_sync.sv
// Three-stage synchroniser and agreement filter for asynchronous pin levels.
`timescale 1ns/1ps
`default_nettype none
module chg_pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] pins,
  chg_line_if.filt lines
);
  import chg_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } chg_sync_t;

  chg_sync_t r;
  chg_sync_t next_r;

  // A change is accepted only once the second and third stages agree, so
  // a single-sample glitch never reaches the bus logic.
  always_comb begin
    next_r = r;
    next_r.s1 = pins;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.level[i] = r.s2[i];
      end
    end
  end

  // Idle bus lines are high, so every stage resets high.
  always_ff @(posedge mclk) begin
    if (srst) begin
      r <= '{s1: '1, s2: '1, s3: '1, level: '1};
    end else begin
      r <= next_r;
    end
  end

  assign lines.level = r.level;
endmodule : chg_pin_sync
`default_nettype wire

// ===== rtl/chg_ctrl_regs.sv
// Two-wire serial slave holding the charger configuration, float voltage, identity and current.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - The charger configuration register at 0x01 resets to 0x30.
// - Configuration bits 7:6 are a read-write input current cap code.
// - Configuration bits 5:4 are a read-write weak-battery threshold code from 3.4 V to 3.7 V.
// - Configuration bit 3 is read-write and turns automatic end-of-charge cutoff on or off.
// - The float-voltage register at 0x02 resets to 0x0a.
// - Float-voltage bits 7:2 are a read-write float voltage code resetting to 000010.
// - The chip identity register reads the same at address 0x03 and at 0x3b.
// - Identity bits 7:5 are a fixed read-only supplier code.
// - Identity bits 4:3 are read-only part-variant bits.
// - Identity bits 2:0 are a read-only silicon revision minor number.
// - The charge-current register at 0x04 resets to 0x89.
// - Writing 1 to charge-current bit 7 returns all charge parameter registers to defaults.
// - The parameter-reset bit always reads back as 1.
// - Charge-current bits 6:4 are a read-write maximum charge current code.
// - Charge-current bits 2:0 are a read-write termination current code.
// - Register addresses and data travel over the two-wire bus most significant bit first.
module chg_ctrl_regs (
  input wire logic mclk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [1:0] input_current_cap,
  output logic [1:0] weak_battery_level,
  output logic end_of_charge_cutoff_on,
  output logic charger_disable,
  output logic high_impedance_mode,
  output logic boost_mode,
  output logic [5:0] float_voltage_code,
  output logic otg_active_high,
  output logic otg_pin_enable,
  output logic [2:0] max_charge_current_code,
  output logic [2:0] cutoff_current_code
);
  import chg_pkg::*;

  // ----------------------------------------------------------------
  // Pin filtering
  // ----------------------------------------------------------------
  chg_line_if lines ();

  chg_pin_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .mclk(mclk),
    .srst(srst),
    .pins({scl_in, sda_in}),
    .lines(lines)
  );

  logic scl;
  logic sda;
  assign scl = lines.level[1];
  assign sda = lines.level[0];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    chg_bus_state_t st;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic rw;
    logic master_ack;
    logic drive_low;
    logic scl_q;
    logic sda_q;
    logic [7:0] charger_config_reg;
    logic [7:0] float_voltage_ctrl;
    logic [2:0] max_cur;
    logic [2:0] cut_cur;
  } chg_state_t;

  localparam chg_state_t CHG_STATE_RESET = '{
    st: CHG_IDLE,
    bit_cnt: 4'h0,
    shreg: 8'h00,
    ptr: 8'h00,
    rw: 1'b0,
    master_ack: 1'b0,
    drive_low: 1'b0,
    scl_q: 1'b1,
    sda_q: 1'b1,
    charger_config_reg: CHG_CONFIG_RESET,
    float_voltage_ctrl: CHG_FLOAT_RESET,
    max_cur: CHG_CURRENT_RESET[CHG_MAXCUR_LSB +: 3],
    cut_cur: CHG_CURRENT_RESET[CHG_CUTCUR_LSB +: 3]
  };

  chg_state_t r;
  chg_state_t next_r;

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_value(input chg_state_t s);
    logic [7:0] v;
    v = CHG_UNMAPPED_READ;
    if (s.ptr == CHG_CONFIG_ADDR) begin
      v = s.charger_config_reg;
    end else if (s.ptr == CHG_FLOAT_ADDR) begin
      v = s.float_voltage_ctrl;
    end else if (s.ptr == CHG_ID_ADDR || s.ptr == CHG_ID_ALIAS_ADDR) begin
      v[CHG_SUPPLIER_LSB +: 3] = CHG_SUPPLIER_CODE;
      v[CHG_VARIANT_LSB +: 2] = CHG_VARIANT_CODE;
      v[CHG_REVISION_LSB +: 3] = CHG_REVISION_CODE;
    end else if (s.ptr == CHG_CURRENT_ADDR) begin
      v[CHG_PARAM_RESET_BIT] = 1'b1;
      v[CHG_MAXCUR_LSB +: 3] = s.max_cur;
      // The unused bit keeps its default of 1.
      v[CHG_RESERVED_BIT] = CHG_CURRENT_RESET[CHG_RESERVED_BIT];
      v[CHG_CUTCUR_LSB +: 3] = s.cut_cur;
    end
    return v;
  endfunction : read_value

  // ----------------------------------------------------------------
  // Bus sequencing and register writes
  // ----------------------------------------------------------------
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] rd_byte;

  assign scl_rise = scl && !r.scl_q;
  assign scl_fall = !scl && r.scl_q;
  assign start_seen = scl && r.scl_q && r.sda_q && !sda;
  assign stop_seen = scl && r.scl_q && !r.sda_q && sda;
  assign rd_byte = read_value(r);

  always_comb begin
    next_r = r;
    next_r.scl_q = scl;
    next_r.sda_q = sda;
    if (start_seen) begin
      // A repeated start keeps the register pointer for the read that follows.
      next_r.st = CHG_DEV_ADDR;
      next_r.bit_cnt = 4'h0;
      next_r.drive_low = 1'b0;
    end else if (stop_seen) begin
      next_r.st = CHG_IDLE;
      next_r.drive_low = 1'b0;
    end else begin
      case (r.st)
        CHG_IDLE: begin
          next_r.drive_low = 1'b0;
        end
        CHG_DEV_ADDR, CHG_REG_ADDR, CHG_WR_DATA: begin
          if (scl_rise) begin
            next_r.shreg = {r.shreg[6:0], sda};
            next_r.bit_cnt = r.bit_cnt + 4'h1;
          end else if (scl_fall && r.bit_cnt == CHG_BYTE_BITS) begin
            next_r.bit_cnt = 4'h0;
            if (r.st == CHG_DEV_ADDR) begin
              if (r.shreg[7:1] == CHG_SLAVE_ADDR) begin
                next_r.rw = r.shreg[0];
                next_r.drive_low = 1'b1;
                next_r.st = CHG_DEV_ACK;
              end else begin
                next_r.st = CHG_IDLE;
              end
            end else if (r.st == CHG_REG_ADDR) begin
              next_r.ptr = r.shreg;
              next_r.drive_low = 1'b1;
              next_r.st = CHG_REG_ACK;
            end else begin
              next_r.drive_low = 1'b1;
              next_r.st = CHG_WR_ACK;
              next_r.ptr = r.ptr + 8'h01;
              if (r.ptr == CHG_CONFIG_ADDR) begin
                next_r.charger_config_reg = r.shreg;
              end else if (r.ptr == CHG_FLOAT_ADDR) begin
                next_r.float_voltage_ctrl = r.shreg;
              end else if (r.ptr == CHG_CURRENT_ADDR) begin
                if (r.shreg[CHG_PARAM_RESET_BIT]) begin
                  // The reset wins over the rest of the same byte.
                  next_r.charger_config_reg = CHG_CONFIG_RESET;
                  next_r.float_voltage_ctrl = CHG_FLOAT_RESET;
                  next_r.max_cur = CHG_CURRENT_RESET[CHG_MAXCUR_LSB +: 3];
                  next_r.cut_cur = CHG_CURRENT_RESET[CHG_CUTCUR_LSB +: 3];
                end else begin
                  next_r.max_cur = r.shreg[CHG_MAXCUR_LSB +: 3];
                  next_r.cut_cur = r.shreg[CHG_CUTCUR_LSB +: 3];
                end
              end
              // Identity and unmapped addresses take the acknowledge but store nothing.
            end
          end
        end
        CHG_DEV_ACK: begin
          if (scl_fall) begin
            next_r.bit_cnt = 4'h0;
            if (r.rw) begin
              next_r.shreg = rd_byte;
              next_r.drive_low = !rd_byte[7];
              next_r.st = CHG_RD_DATA;
            end else begin
              next_r.drive_low = 1'b0;
              next_r.st = CHG_REG_ADDR;
            end
          end
        end
        CHG_REG_ACK, CHG_WR_ACK: begin
          if (scl_fall) begin
            next_r.drive_low = 1'b0;
            next_r.bit_cnt = 4'h0;
            next_r.st = CHG_WR_DATA;
          end
        end
        CHG_RD_DATA: begin
          if (scl_fall) begin
            next_r.bit_cnt = r.bit_cnt + 4'h1;
            next_r.shreg = {r.shreg[6:0], 1'b0};
            if (r.bit_cnt == CHG_BYTE_BITS - 4'h1) begin
              next_r.drive_low = 1'b0;
              next_r.ptr = r.ptr + 8'h01;
              next_r.st = CHG_RD_ACK;
            end else begin
              next_r.drive_low = !r.shreg[6];
            end
          end
        end
        CHG_RD_ACK: begin
          if (scl_rise) begin
            next_r.master_ack = !sda;
          end else if (scl_fall) begin
            next_r.bit_cnt = 4'h0;
            if (r.master_ack) begin
              next_r.shreg = rd_byte;
              next_r.drive_low = !rd_byte[7];
              next_r.st = CHG_RD_DATA;
            end else begin
              // A refused byte ends the read; wait for the stop.
              next_r.st = CHG_IDLE;
            end
          end
        end
        default: begin
          next_r.st = CHG_IDLE;
          next_r.drive_low = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      r <= CHG_STATE_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The line is open drain: it only ever pulls low.
  assign sda_out = 1'b0;
  assign sda_oe = r.drive_low;
  assign input_current_cap = r.charger_config_reg[CHG_INCAP_LSB +: 2];
  assign weak_battery_level = r.charger_config_reg[CHG_WEAK_LSB +: 2];
  assign end_of_charge_cutoff_on = r.charger_config_reg[CHG_CUTOFF_BIT];
  assign charger_disable = r.charger_config_reg[CHG_DISABLE_BIT];
  assign high_impedance_mode = r.charger_config_reg[CHG_HIZ_BIT];
  assign boost_mode = r.charger_config_reg[CHG_BOOST_BIT];
  assign float_voltage_code = r.float_voltage_ctrl[CHG_FLOAT_LSB +: 6];
  assign otg_active_high = r.float_voltage_ctrl[CHG_OTG_POL_BIT];
  assign otg_pin_enable = r.float_voltage_ctrl[CHG_OTG_EN_BIT];
  assign max_charge_current_code = r.max_cur;
  assign cutoff_current_code = r.cut_cur;
endmodule : chg_ctrl_regs
`default_nettype wire

// ===== tb/chg_host_model.sv
// Bus master model driving the two-wire serial bus of the register bank.
`timescale 1ns/1ps
`default_nettype none
module chg_host_model (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  import chg_pkg::*;
  // Each phase is far longer than the pin filter delay, so levels are seen settled.
  localparam int HALF = 12;
  logic acked;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    acked = 1'b1;
  end
  task automatic step(input logic c, input logic p);
    scl <= c;
    sda_pull <= p;
    repeat (HALF) @(posedge mclk);
  endtask : step
  task automatic pulse(output logic b);
    step(1'b1, sda_pull);
    b = sda;
    step(1'b0, sda_pull);
  endtask : pulse
  task automatic byte_out(input logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      step(1'b0, ~d[i]);
      pulse(b);
    end
    step(1'b0, 1'b0);
    pulse(b);
    acked &= ~b;
  endtask : byte_out
  task automatic byte_in(output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      step(1'b0, 1'b0);
      pulse(b);
      d[i] = b;
    end
    step(1'b0, 1'b0);
    pulse(b);
  endtask : byte_in
  task automatic access(input logic is_read, input logic [7:0] a, inout logic [7:0] d,
    output logic ok);
    acked = 1'b1;
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    byte_out({CHG_SLAVE_ADDR, 1'b0});
    byte_out(a);
    if (is_read) begin
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
      byte_out({CHG_SLAVE_ADDR, 1'b1});
      byte_in(d);
    end else begin
      byte_out(d);
    end
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    ok = acked;
  endtask : access
endmodule : chg_host_model
`default_nettype wire

// ===== tb/chg_regs_assertions.sv
// Port checks for the charger control register bank.
`timescale 1ns/1ps
`default_nettype none
module chg_regs_chk (
  input wire logic mclk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe,
  input wire logic [1:0] input_current_cap,
  input wire logic [1:0] weak_battery_level,
  input wire logic end_of_charge_cutoff_on,
  input wire logic [5:0] float_voltage_code,
  input wire logic [2:0] max_charge_current_code,
  input wire logic [2:0] cutoff_current_code
);
  logic scl_prev;
  logic [3:0] since_fall;
  logic [4:0] cfg;
  logic [5:0] cur;
  assign cfg = {input_current_cap, weak_battery_level, end_of_charge_cutoff_on};
  assign cur = {max_charge_current_code, cutoff_current_code};
  // The pin filter delays each reaction to a clock fall, so a short window is allowed.
  always_ff @(posedge mclk) begin
    scl_prev <= scl_in;
    if (srst) begin
      since_fall <= 4'hf;
    end else if (scl_prev && !scl_in) begin
      since_fall <= 4'h0;
    end else if (since_fall != 4'hf) begin
      since_fall <= since_fall + 4'h1;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  sequence s_after_fall;
    since_fall >= 4'h1 && since_fall <= 4'h8;
  endsequence
  sequence s_start;
    scl_in && $fell(sda_in);
  endsequence
  a_cfg_reset:
    assert property (srst |=> cfg == 5'h06) else $error("config reset");
  a_float_reset:
    assert property (srst |=> float_voltage_code == 6'h02) else $error("float reset");
  a_cur_reset:
    assert property (srst |=> cur == 6'h01) else $error("current reset");
  a_cfg_timing:
    assert property (disable iff (srst) $changed(cfg) |-> s_after_fall) else $error("config late");
  a_float_timing:
    assert property (disable iff (srst) $changed(float_voltage_code) |-> s_after_fall)
      else $error("float late");
  a_cur_timing:
    assert property (disable iff (srst) $changed(cur) |-> s_after_fall) else $error("current late");
  a_sda_timing:
    assert property (disable iff (srst) $changed(sda_oe) |-> s_after_fall) else $error("sda late");
  a_start_quiet:
    assert property (disable iff (srst) s_start |-> !sda_oe [*8]) else $error("sda at start");
endmodule : chg_regs_chk
bind chg_ctrl_regs chg_regs_chk u_chk (.mclk, .srst, .scl_in, .sda_in, .sda_oe, .input_current_cap,
  .weak_battery_level, .end_of_charge_cutoff_on, .float_voltage_code, .max_charge_current_code,
  .cutoff_current_code);
`default_nettype wire

// ===== tb/chg_ctrl_regs_bench.sv
// Self-checking bench for the charger control register bank.
`timescale 1ns/1ps
`default_nettype none
module chg_ctrl_regs_bench;
  import chg_pkg::*;
  logic mclk, srst, scl, sda_pull, sda_out, sda_oe, end_of_charge_cutoff_on, charger_disable;
  logic high_impedance_mode, boost_mode, otg_active_high, otg_pin_enable;
  logic [1:0] input_current_cap, weak_battery_level;
  logic [2:0] max_charge_current_code, cutoff_current_code;
  logic [5:0] float_voltage_code;
  logic [7:0] v, cfg_out, flt_out, cur_out;
  int err_count = 0;
  int checked = 0;
  // Pull-up on the data wire: it is low while either side pulls it.
  wire logic sda = ~(sda_pull | (sda_oe & ~sda_out));
  assign cfg_out = {input_current_cap, weak_battery_level, end_of_charge_cutoff_on,
    charger_disable, high_impedance_mode, boost_mode};
  assign flt_out = {float_voltage_code, otg_active_high, otg_pin_enable};
  assign cur_out = {1'b0, max_charge_current_code, 1'b0, cutoff_current_code};
  chg_ctrl_regs u_dut (.mclk, .srst, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
    .input_current_cap, .weak_battery_level, .end_of_charge_cutoff_on, .charger_disable,
    .high_impedance_mode, .boost_mode, .float_voltage_code, .otg_active_high,
    .otg_pin_enable, .max_charge_current_code, .cutoff_current_code);
  chg_host_model u_host (.mclk, .sda, .scl, .sda_pull);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check8
  task automatic xfer(input logic is_read, input logic [7:0] a, input logic [7:0] d);
    logic ok;
    logic [7:0] got;
    got = d;
    u_host.access(is_read, a, got, ok);
    check8("acknowledge", 8'h01, {7'h00, ok});
    if (is_read) begin
      check8("register read", d, got);
    end
  endtask : xfer
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  // A full run takes about two fifths of this bound; it only cuts a hang short.
  initial begin
    repeat (95000) @(posedge mclk);
    err_count++;
    wrap_up();
  end
  initial begin
    srst = 1'b1;
    v = 8'h00;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    repeat (6) @(posedge mclk);
    check8("data pin drive level", 8'h00, {7'h00, sda_out});
    xfer(1'b1, CHG_CONFIG_ADDR, 8'h30);
    xfer(1'b1, CHG_FLOAT_ADDR, 8'h0a);
    check8("float code", 8'h02, {2'h0, float_voltage_code});
    xfer(1'b1, CHG_CURRENT_ADDR, 8'h89);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, CHG_CONFIG_ADDR, v);
      xfer(1'b1, CHG_CONFIG_ADDR, v);
      check8("config outputs", v, cfg_out);
      xfer(1'b0, CHG_FLOAT_ADDR, v);
      xfer(1'b1, CHG_FLOAT_ADDR, v);
      check8("float outputs", v, flt_out);
      v = v + 8'h55;
    end
    xfer(1'b0, CHG_ID_ADDR, 8'hff);
    xfer(1'b1, CHG_ID_ADDR, {CHG_SUPPLIER_CODE, CHG_VARIANT_CODE, CHG_REVISION_CODE});
    xfer(1'b1, CHG_ID_ALIAS_ADDR, {CHG_SUPPLIER_CODE, CHG_VARIANT_CODE, CHG_REVISION_CODE});
    xfer(1'b0, CHG_CURRENT_ADDR, 8'h77);
    xfer(1'b1, CHG_CURRENT_ADDR, 8'hff);
    check8("current outputs", 8'h77, cur_out);
    xfer(1'b0, CHG_CURRENT_ADDR, 8'h50);
    xfer(1'b1, CHG_CURRENT_ADDR, 8'hd8);
    xfer(1'b0, CHG_CURRENT_ADDR, 8'hff);
    xfer(1'b1, CHG_CONFIG_ADDR, 8'h30);
    xfer(1'b1, CHG_FLOAT_ADDR, 8'h0a);
    xfer(1'b1, CHG_CURRENT_ADDR, 8'h89);
    xfer(1'b0, CHG_CONFIG_ADDR, 8'h12);
    srst <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    repeat (6) @(posedge mclk);
    xfer(1'b1, CHG_CONFIG_ADDR, 8'h30);
    wrap_up();
  end
endmodule : chg_ctrl_regs_bench
`default_nettype wire
